// >>> core/ssm_status_monitor.sv
// Notes on behaviour
// - Point number is six bits from inputs 16..1B, 16 weight 1, 1B weight 32.
// - Present position drives outputs 10..15 with output 10 as LSB.
// - Polarity 1: closed contact asserts a bit; polarity 0: open asserts it.
// - Point-input count setting limits how many select inputs are used.
// - Fast jog minus, fast jog plus and homing codes follow the count setting.
// - Keep the 14 latest error codes; up and down keys step through them.
// - Codes 11, 13, 36, 37, 39, 93 and 95 never enter the history.
// - Display flashes while an error is present.
// - Regen load percent, 100 at trip; valid only when regen select is 0 or 1.
// - Overload factor is present load as percent of rated load.
// - Inertia readout is the inertia setting unchanged.
// - Signed pulse sums from power-on within +/-2147483647, overflow beyond.
// - Holding set about 5 seconds clears the pulse sums.
// - Automatic motor recognition indicator is always on.
// - Point inputs and position outputs are monitored under hex signal numbers.
//
// The implementer's own choices: the address map and the APB slave port.
module ssm_status_monitor
    import ssm_pkg::*;
#(
    parameter int LONG_PRESS_CYC = SSM_LONG_PRESS_CYC,
    parameter int FLASH_CYC = SSM_FLASH_CYC
)
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // APB slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // Contacts, keys and pulse events
    input wire logic [5:0] POINT_CONTACT_I,
    input wire logic KEY_UP_I,
    input wire logic KEY_DOWN_I,
    input wire logic KEY_SET_I,
    input wire logic FB_PULSE_I,
    input wire logic FB_DIR_NEG_I,
    input wire logic CMD_PULSE_I,
    input wire logic CMD_DIR_NEG_I,
    // Monitor outputs
    output logic [5:0] POSITION_OUT_O,
    output logic [5:0] POINT_NUM_O,
    output logic JOG_FAST_NEG_O,
    output logic JOG_FAST_POS_O,
    output logic HOMING_CMD_O,
    output logic DISPLAY_FLASH_O,
    output logic MOTOR_RECOG_O,
    output logic IRQ_O
);

    // ****************************************************************
    // Input synchronisers (three stages, accept when stages 2 and 3 agree)
    // ****************************************************************
    logic [8:0] raw_w;
    logic [8:0] s1_r, s2_r, s3_r, clean_r;
    assign raw_w = {KEY_SET_I, KEY_DOWN_I, KEY_UP_I, POINT_CONTACT_I};

    // Contacts and keys are asynchronous; the agreement also filters glitches
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            clean_r <= '0;
        end
        else
        begin
            s1_r <= raw_w;
            s2_r <= s1_r;
            s3_r <= s2_r;
            clean_r <= (s2_r & s3_r) | (clean_r & (s2_r | s3_r));
        end
    end

    ssm_keys_t keys_w, keys_q_r;
    assign keys_w = '{up: clean_r[6], down: clean_r[7], set: clean_r[8]};

    // ****************************************************************
    // Configuration and register decode
    // ****************************************************************
    logic [31:0] cfg_r, load_r, irq_en_r, err_in_r;
    logic [5:0] pos_r;
    logic wr_w, rd_w;
    logic pol_w;
    logic [2:0] cnt_w;
    logic [7:0] regen_sel_w;
    logic [15:0] inertia_w;
    assign wr_w = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_w = PSEL_I & ~PWRITE_I & ~PENABLE_I;
    assign pol_w = cfg_r[SSM_CFG_POL_BIT];
    assign cnt_w = cfg_r[SSM_CFG_CNT_LSB +: 3];
    assign regen_sel_w = cfg_r[SSM_CFG_REGEN_LSB +: 8];
    assign inertia_w = cfg_r[SSM_CFG_INERTIA_LSB +: 16];

    // ****************************************************************
    // Point number decode
    // ****************************************************************
    logic [5:0] asserted_w, mask_w, point_w, top_w;
    assign asserted_w = pol_w ? clean_r[5:0] : ~clean_r[5:0];
    assign mask_w = 6'(7'h40 >> (3'h6 - ((cnt_w > 3'h6) ? 3'h6 : cnt_w))) - 6'h01;
    assign point_w = asserted_w & mask_w;
    assign top_w = mask_w; // Highest code of the enabled range
    // Reserved top three codes carry fast jog and homing
    logic jneg_w, jpos_w, home_w;
    assign jneg_w = (point_w == top_w - 6'h02) && (mask_w != 6'h00);
    assign jpos_w = (point_w == top_w - 6'h01) && (mask_w != 6'h00);
    assign home_w = (point_w == top_w) && (mask_w != 6'h00);

    // ****************************************************************
    // Error history
    // ****************************************************************
    logic [7:0] hist_r [SSM_HIST_DEPTH];
    logic [3:0] hist_cnt_r, hist_sel_r;
    logic [7:0] err_prev_r;
    logic err_new_w, recordable_w;
    logic [7:0] code_w;
    assign code_w = err_in_r[7:0];
    // Power and storage faults are not logged
    assign recordable_w = !(code_w inside {8'h0B, 8'h0D, 8'h24, 8'h25, 8'h27, 8'h5D, 8'h5F});
    assign err_new_w = (code_w != 8'h00) && (code_w != err_prev_r) && recordable_w;

    // Shift register keeps newest at entry 0
    genvar gi;
    generate
        for (gi = 0; gi < SSM_HIST_DEPTH; gi++)
        begin : g_hist
            always_ff @(posedge CLK_I or negedge RST_B_I)
            begin
                if (!RST_B_I)
                    hist_r[gi] <= '0;
                else if (err_new_w)
                    hist_r[gi] <= (gi == 0) ? code_w : hist_r[(gi == 0) ? 0 : gi - 1];
            end
        end
    endgenerate

    // Count held entries and key stepping of selection
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            hist_cnt_r <= '0;
            hist_sel_r <= '0;
            err_prev_r <= '0;
            keys_q_r <= '0;
        end
        else
        begin
            err_prev_r <= code_w;
            keys_q_r <= keys_w;
            if (err_new_w && hist_cnt_r < 4'(SSM_HIST_DEPTH))
                hist_cnt_r <= hist_cnt_r + 4'h1;
            if (keys_w.up && !keys_q_r.up && hist_sel_r < 4'(SSM_HIST_DEPTH - 1))
                hist_sel_r <= hist_sel_r + 4'h1;
            else if (keys_w.down && !keys_q_r.down && hist_sel_r != 4'h0)
                hist_sel_r <= hist_sel_r - 4'h1;
        end
    end

    // ****************************************************************
    // Flashing display while an error is active
    // ****************************************************************
    ssm_disp_t disp_r;
    logic [31:0] flash_cnt_r;
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            disp_r <= SSM_DISP_STEADY;
            flash_cnt_r <= '0;
        end
        else
        begin
            flash_cnt_r <= (flash_cnt_r >= 32'(FLASH_CYC - 1)) ? '0 : flash_cnt_r + 32'h1;
            case (disp_r)
                SSM_DISP_STEADY: if (code_w != 8'h00) disp_r <= SSM_DISP_FLASH_ON;
                SSM_DISP_FLASH_ON, SSM_DISP_FLASH_OFF:
                    if (code_w == 8'h00)
                        disp_r <= SSM_DISP_STEADY;
                    else if (flash_cnt_r == '0)
                        disp_r <= (disp_r == SSM_DISP_FLASH_ON) ? SSM_DISP_FLASH_OFF
                                                                 : SSM_DISP_FLASH_ON;
                default: disp_r <= SSM_DISP_STEADY;
            endcase
        end
    end

    // ****************************************************************
    // Pulse sums with long-press clear
    // ****************************************************************
    logic signed [31:0] fb_sum_r, cmd_sum_r;
    logic fb_ovf_r, cmd_ovf_r;
    logic [31:0] press_cnt_r;
    logic long_clr_w;
    logic signed [32:0] fb_nxt, cmd_nxt;
    assign long_clr_w = keys_w.set && (press_cnt_r == 32'(LONG_PRESS_CYC - 1));
    assign fb_nxt = 33'(fb_sum_r) + (FB_DIR_NEG_I ? -33'sd1 : 33'sd1);
    assign cmd_nxt = 33'(cmd_sum_r) + (CMD_DIR_NEG_I ? -33'sd1 : 33'sd1);
    logic fb_out_w, cmd_out_w;
    assign fb_out_w = FB_PULSE_I && (fb_nxt > SSM_SUM_MAX || fb_nxt < -SSM_SUM_MAX);
    assign cmd_out_w = CMD_PULSE_I && (cmd_nxt > SSM_SUM_MAX || cmd_nxt < -SSM_SUM_MAX);

    // Sums saturate at the range edge; overflow holds until clear
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            press_cnt_r <= '0;
            fb_sum_r <= '0;
            cmd_sum_r <= '0;
            fb_ovf_r <= 1'b0;
            cmd_ovf_r <= 1'b0;
        end
        else
        begin
            press_cnt_r <= !keys_w.set ? '0 : (long_clr_w ? press_cnt_r : press_cnt_r + 32'h1);
            if (long_clr_w && !keys_q_r.set == 1'b0 && press_cnt_r != '1)
            begin
                fb_sum_r <= '0;
                cmd_sum_r <= '0;
                fb_ovf_r <= fb_out_w; // Set wins over clear
                cmd_ovf_r <= cmd_out_w;
            end
            else
            begin
                if (FB_PULSE_I && !fb_out_w)
                    fb_sum_r <= 32'(fb_nxt);
                if (CMD_PULSE_I && !cmd_out_w)
                    cmd_sum_r <= 32'(cmd_nxt);
                fb_ovf_r <= fb_ovf_r | fb_out_w;
                cmd_ovf_r <= cmd_ovf_r | cmd_out_w;
            end
        end
    end

    // ****************************************************************
    // Interrupt status: set wins over clear
    // ****************************************************************
    logic [SSM_IRQ_BITS-1:0] irq_stat_r, irq_ev_w, irq_clr_w;
    assign irq_ev_w = {cmd_out_w, fb_out_w, err_new_w};
    assign irq_clr_w = (wr_w && PADDR_I == SSM_OFF_IRQ_CLR) ? PWDATA_I[SSM_IRQ_BITS-1:0] : '0;

    // ****************************************************************
    // APB registers and outputs
    // ****************************************************************
    logic [31:0] rd_mux_w;
    logic [7:0] regen_pct_w;
    // Regen readout reads zero when the selection makes it meaningless
    assign regen_pct_w = (regen_sel_w <= 8'h01) ? load_r[7:0] : 8'h00;
    always_comb
    begin
        case (PADDR_I)
            SSM_OFF_CONFIG: rd_mux_w = cfg_r;
            SSM_OFF_ERRIN: rd_mux_w = err_in_r;
            SSM_OFF_POSOUT: rd_mux_w = {26'h0, pos_r};
            SSM_OFF_POINT: rd_mux_w = {20'h0, 4'(hist_cnt_r), 2'h0, point_w};
            SSM_OFF_HIST: rd_mux_w = {20'h0, hist_sel_r, hist_r[hist_sel_r]};
            SSM_OFF_FBSUM: rd_mux_w = fb_sum_r;
            SSM_OFF_CMDSUM: rd_mux_w = cmd_sum_r;
            // Overload byte, regen byte, inertia half
            SSM_OFF_LOAD: rd_mux_w = {inertia_w, regen_pct_w, load_r[15:8]};
            SSM_OFF_IRQ_STAT: rd_mux_w = {29'h0, irq_stat_r};
            SSM_OFF_IRQ_EN: rd_mux_w = irq_en_r;
            SSM_OFF_STATUS: rd_mux_w = {28'h0, 1'b1, cmd_ovf_r, fb_ovf_r, disp_r != SSM_DISP_STEADY};
            default: rd_mux_w = 32'h0000_0000;
        endcase
    end

    // Register writes, read data capture and output flops
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            cfg_r <= SSM_CFG_RESET;
            load_r <= '0;
            err_in_r <= '0;
            pos_r <= '0;
            irq_en_r <= '0;
            irq_stat_r <= '0;
            PRDATA_O <= '0;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            POSITION_OUT_O <= '0;
            POINT_NUM_O <= '0;
            JOG_FAST_NEG_O <= 1'b0;
            JOG_FAST_POS_O <= 1'b0;
            HOMING_CMD_O <= 1'b0;
            DISPLAY_FLASH_O <= 1'b0;
            MOTOR_RECOG_O <= 1'b0;
            IRQ_O <= 1'b0;
        end
        else
        begin
            if (wr_w && PADDR_I == SSM_OFF_CONFIG) cfg_r <= PWDATA_I;
            if (wr_w && PADDR_I == SSM_OFF_LOAD) load_r <= PWDATA_I;
            if (wr_w && PADDR_I == SSM_OFF_ERRIN) err_in_r <= PWDATA_I;
            if (wr_w && PADDR_I == SSM_OFF_POSOUT) pos_r <= PWDATA_I[5:0];
            if (wr_w && PADDR_I == SSM_OFF_IRQ_EN) irq_en_r <= {29'h0, PWDATA_I[2:0]};
            irq_stat_r <= (irq_stat_r & ~irq_clr_w) | irq_ev_w;
            if (rd_w) PRDATA_O <= rd_mux_w;
            PREADY_O <= PSEL_I & ~PENABLE_I; // No wait states
            PSLVERR_O <= 1'b0;
            POSITION_OUT_O <= pos_r;
            POINT_NUM_O <= point_w;
            JOG_FAST_NEG_O <= jneg_w;
            JOG_FAST_POS_O <= jpos_w;
            HOMING_CMD_O <= home_w;
            DISPLAY_FLASH_O <= (disp_r == SSM_DISP_FLASH_ON);
            MOTOR_RECOG_O <= 1'b1;
            IRQ_O <= |(irq_stat_r & irq_en_r[2:0]);
        end
    end

endmodule : ssm_status_monitor

// >>> shared/ssm_pkg.sv
package ssm_pkg;

    // ****************************************************************
    // Register map (APB byte addresses)
    // ****************************************************************
    localparam logic [7:0] SSM_OFF_CONFIG = 8'h00;
    localparam logic [7:0] SSM_OFF_ERRIN = 8'h04;
    localparam logic [7:0] SSM_OFF_POSOUT = 8'h08;
    localparam logic [7:0] SSM_OFF_POINT = 8'h0C;
    localparam logic [7:0] SSM_OFF_HIST = 8'h10;
    localparam logic [7:0] SSM_OFF_FBSUM = 8'h14;
    localparam logic [7:0] SSM_OFF_CMDSUM = 8'h18;
    localparam logic [7:0] SSM_OFF_LOAD = 8'h1C;
    localparam logic [7:0] SSM_OFF_IRQ_STAT = 8'h20;
    localparam logic [7:0] SSM_OFF_IRQ_EN = 8'h24;
    localparam logic [7:0] SSM_OFF_IRQ_CLR = 8'h28;
    localparam logic [7:0] SSM_OFF_STATUS = 8'h2C;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int SSM_CFG_POL_BIT = 0;
    localparam int SSM_CFG_CNT_LSB = 4;
    localparam int SSM_CFG_REGEN_LSB = 8;
    localparam int SSM_CFG_INERTIA_LSB = 16;
    localparam logic [31:0] SSM_CFG_RESET = 32'h0064_0061;
    localparam int SSM_POINT_BITS = 6;
    localparam int SSM_HIST_DEPTH = 14;
    localparam int SSM_IRQ_BITS = 3;
    localparam int SSM_IRQ_ERR = 0;
    localparam int SSM_IRQ_FB_OVF = 1;
    localparam int SSM_IRQ_CMD_OVF = 2;
    localparam logic signed [32:0] SSM_SUM_MAX = 33'sh0_7FFF_FFFF;
    localparam logic [7:0] SSM_REGEN_TRIP_PCT = 8'h64;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int SSM_CLK_HZ = 10000000;
    localparam int SSM_LONG_PRESS_S = 5;
    localparam int SSM_LONG_PRESS_CYC = SSM_CLK_HZ * SSM_LONG_PRESS_S;
    localparam int SSM_FLASH_CYC = 2500000;

    // Synchronised console keys
    typedef struct packed {
        logic up;
        logic down;
        logic set;
    } ssm_keys_t;

    // Console display state
    typedef enum logic [1:0] {
        SSM_DISP_STEADY = 2'b00,
        SSM_DISP_FLASH_ON = 2'b01,
        SSM_DISP_FLASH_OFF = 2'b10
    } ssm_disp_t;

endpackage : ssm_pkg

// >>> testbench/ssm_status_sva.sv
module ssm_status_sva
    import ssm_pkg::*;
#(
    parameter int LONG_PRESS_CYC = 20,
    parameter int FLASH_CYC = 4
)
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_B_I,
    // APB
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    // Monitor outputs
    input wire logic [5:0] POSITION_OUT_O,
    input wire logic JOG_FAST_NEG_O,
    input wire logic JOG_FAST_POS_O,
    input wire logic HOMING_CMD_O,
    input wire logic DISPLAY_FLASH_O,
    input wire logic MOTOR_RECOG_O
);
    // Bound allows a blink half period of up to twice nominal
    localparam int FLASH_BOUND = 2 * FLASH_CYC;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_B_I);

    // ************
    // APB handshake
    // ************
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_access;
        PSEL_I && PENABLE_I && PREADY_O;
    endsequence

    a_ready_follows:
        assert property (s_setup |=> s_access)
        else $error("ready missing in access cycle");
    a_ready_access:
        assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I) ##0 s_access)
        else $error("ready outside access cycle");
    a_slverr_low:
        assert property (PREADY_O |-> PSLVERR_O == 1'b0)
        else $error("error response given");
    a_rdata_source:
        assert property (!$stable(PRDATA_O) |-> $past(PSEL_I && !PENABLE_I && !PWRITE_I))
        else $error("read data changed without read setup");

    // ************
    // Monitor outputs
    // ************
    // Write lands at the access edge, the output flop follows one edge later
    a_posout_source:
        assert property (!$stable(POSITION_OUT_O)
            |-> $past(PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == SSM_OFF_POSOUT, 2))
        else $error("position output changed without write");
    a_flash_blinks:
        assert property (DISPLAY_FLASH_O |-> ##[1:FLASH_BOUND] !DISPLAY_FLASH_O)
        else $error("display stuck lit");
    a_jog_exclusive:
        assert property ($onehot0({JOG_FAST_NEG_O, JOG_FAST_POS_O, HOMING_CMD_O}))
        else $error("two point codes at once");
    a_recog_always:
        assert property ($past(RST_B_I) |-> MOTOR_RECOG_O)
        else $error("recognition indicator low");
endmodule : ssm_status_sva

// >>> testbench/ssm_io_partner.sv
module ssm_io_partner
(
    // Clock
    input wire logic clk_i,
    // Contacts and console keys
    output logic [5:0] contact_o,
    output logic key_up_o,
    output logic key_down_o,
    output logic key_set_o,
    // Pulse events
    output logic fb_o,
    output logic fb_neg_o,
    output logic cmd_o,
    output logic cmd_neg_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle contacts all open, keys released
    initial
    begin
        contact_o = 6'h00;
        key_set_o = 1'b0;
        {key_up_o, key_down_o} = 2'b00;
        {fb_o, fb_neg_o, cmd_o, cmd_neg_o} = 4'h0;
    end

    // Active-open polarity inverts every wire level
    task automatic set_point(input logic [5:0] p, input logic pol);
        @(posedge clk_i);
        contact_o <= pol ? p : ~p;
    endtask : set_point

    // Spaced single-cycle pulses so no event merges with the next
    task automatic pulses(input int n, input logic neg, input logic fb);
        repeat (n)
        begin
            @(posedge clk_i);
            {fb_o, cmd_o, fb_neg_o, cmd_neg_o} <= {fb, !fb, neg, neg};
            @(posedge clk_i);
            {fb_o, cmd_o} <= 2'b00;
        end
    endtask : pulses

    // Tap up or down; held long enough to pass the three-stage filter
    task automatic step(input logic up);
        @(posedge clk_i);
        {key_up_o, key_down_o} <= {up, !up};
        repeat (8) @(posedge clk_i);
        {key_up_o, key_down_o} <= 2'b00;
        repeat (8) @(posedge clk_i);
    endtask : step

    // Hold the set key for n cycles
    task automatic press(input int n);
        @(posedge clk_i);
        key_set_o <= 1'b1;
        repeat (n) @(posedge clk_i);
        key_set_o <= 1'b0;
    endtask : press
endmodule : ssm_io_partner

// >>> testbench/testbench.sv
module testbench
    import ssm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LP = 20;
    localparam int FL = 4;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, q;
    logic pready, key_set, key_up, key_down, fb, fbn, cmd, cmdn, jneg, jpos, home, flash;
    logic recog, irq, pol;
    logic [5:0] contact, posout, point, p;
    int errors = 0;
    int checks_done = 0;
    int n, e, top, c, k;
    int hist[$];
    int skip[7] = '{11, 13, 36, 37, 39, 93, 95};

    always #50 clk = ~clk;

    ssm_io_partner i_partner (.clk_i(clk), .contact_o(contact), .key_up_o(key_up),
        .key_down_o(key_down), .key_set_o(key_set), .fb_o(fb), .fb_neg_o(fbn), .cmd_o(cmd),
        .cmd_neg_o(cmdn));

    // Console keys come from the partner; timing counts shortened for simulation
    ssm_status_monitor #(.LONG_PRESS_CYC(LP), .FLASH_CYC(FL)) i_dut (.CLK_I(clk),
        .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(),
        .POINT_CONTACT_I(contact), .KEY_UP_I(key_up), .KEY_DOWN_I(key_down), .KEY_SET_I(key_set),
        .FB_PULSE_I(fb), .FB_DIR_NEG_I(fbn), .CMD_PULSE_I(cmd), .CMD_DIR_NEG_I(cmdn),
        .POSITION_OUT_O(posout), .POINT_NUM_O(point), .JOG_FAST_NEG_O(jneg),
        .JOG_FAST_POS_O(jpos), .HOMING_CMD_O(home), .DISPLAY_FLASH_O(flash),
        .MOTOR_RECOG_O(recog), .IRQ_O(irq));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; request held until ready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int t;
        t = 0;
        {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (pready !== 1'b1 && t < 20);
        if (pready !== 1'b1)
        begin
            errors++;
            finish_test();
        end
        r = prdata;
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0000_0000, r);
    endtask : rd

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // Main sequence
    initial
    begin
        void'($urandom(32'h3e3f));
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(SSM_OFF_CONFIG, q);
        chk(q, SSM_CFG_RESET);
        wr(8'h30, 32'hFFFF_FFFF);
        rd(8'h30, q);
        chk(q, 32'h0000_0000);
        wr(SSM_OFF_LOAD, 32'h0000_501E);
        rd(SSM_OFF_LOAD, q);
        chk(q, 32'h0064_1E50);
        wr(SSM_OFF_CONFIG, SSM_CFG_RESET | 32'h0000_0200);
        rd(SSM_OFF_LOAD, q);
        chk(q, 32'h0064_0050);
        chk(32'(recog), 32'h0000_0001);
        $display("test readouts done");
        for (int i = 0; i < 24; i++)
        begin
            n = (i < 16) ? 6 : 3;
            pol = i[0];
            p = (i % 3 == 0) ? 6'($urandom_range(0, 63)) : 6'h3F - 6'(i % 8);
            wr(SSM_OFF_CONFIG, 32'h0064_0000 | (n << 4) | 32'(pol));
            i_partner.set_point(p, pol);
            repeat (6) @(posedge clk);
            top = (1 << n) - 1;
            e = p & top;
            k = (e << 3) | ((e == top - 2) << 2) | ((e == top - 1) << 1) | (e == top);
            chk({point, jneg, jpos, home}, k);
            rd(SSM_OFF_POINT, q);
            chk(q & 32'h0000_003F, e);
        end
        $display("test points done");
        repeat (4)
        begin
            p = 6'($urandom);
            wr(SSM_OFF_POSOUT, 32'(p));
            // Output flop updates on the edge the task returns at; look once settled
            @(negedge clk);
            chk(32'(posout), 32'(p));
            @(posedge clk);
        end
        $display("test position done");
        for (int i = 0; i < 16; i++)
        begin
            do
                c = $urandom_range(1, 99);
            while (c inside {skip});
            hist.push_front(c);
            if (hist.size() > 14)
                void'(hist.pop_back());
            wr(SSM_OFF_ERRIN, c);
            wr(SSM_OFF_ERRIN, 0);
            if (i < 7)
                wr(SSM_OFF_ERRIN, skip[i]);
            wr(SSM_OFF_ERRIN, 0);
        end
        rd(SSM_OFF_POINT, q);
        chk((q >> 8) & 32'h0000_000F, hist.size());
        // Selection is stepped up through every entry, newest first, then once down
        for (int s = 0; s < 14; s++)
        begin
            rd(SSM_OFF_HIST, q);
            chk(q & 32'h0000_0FFF, (s << 8) | hist[s]);
            i_partner.step(1'b1);
        end
        i_partner.step(1'b0);
        rd(SSM_OFF_HIST, q);
        chk((q >> 8) & 32'h0000_000F, 12);
        rd(SSM_OFF_IRQ_STAT, q);
        chk(q & 32'h0000_0001, 1);
        chk(32'(irq), 0);
        wr(SSM_OFF_IRQ_EN, 32'h0000_0001);
        @(posedge clk);
        chk(32'(irq), 1);
        wr(SSM_OFF_IRQ_CLR, 32'h0000_0001);
        @(posedge clk);
        chk(32'(irq), 0);
        wr(SSM_OFF_ERRIN, 32'h0000_0005);
        k = 0;
        repeat (24)
        begin
            @(posedge clk);
            k += int'(flash === 1'b1);
        end
        chk(32'(k inside {[8:16]}), 1);
        wr(SSM_OFF_ERRIN, 0);
        repeat (4) @(posedge clk);
        chk(32'(flash), 0);
        $display("test errors done");
        i_partner.pulses(5, 1'b0, 1'b1);
        i_partner.pulses(3, 1'b1, 1'b0);
        rd(SSM_OFF_FBSUM, q);
        chk(q, 5);
        rd(SSM_OFF_CMDSUM, q);
        chk(q, -3);
        i_partner.press(LP / 2);
        rd(SSM_OFF_FBSUM, q);
        chk(q, 5);
        i_partner.press(LP * 2);
        repeat (4) @(posedge clk);
        rd(SSM_OFF_FBSUM, q);
        chk(q, 0);
        rd(SSM_OFF_CMDSUM, q);
        chk(q, 0);
        // No flashing, no overflow, recognition bit always set
        rd(SSM_OFF_STATUS, q);
        chk(q & 32'h0000_000F, 32'h0000_0008);
        $display("test sums done");
        finish_test();
    end

    // Watchdog well beyond the thousand or so cycles the tests need
    initial
    begin
        #2_000_000;
        errors++;
        finish_test();
    end
endmodule : testbench

bind ssm_status_monitor ssm_status_sva #(.LONG_PRESS_CYC(LONG_PRESS_CYC),
    .FLASH_CYC(FLASH_CYC)) i_sva (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .POSITION_OUT_O(POSITION_OUT_O),
    .JOG_FAST_NEG_O(JOG_FAST_NEG_O), .JOG_FAST_POS_O(JOG_FAST_POS_O),
    .HOMING_CMD_O(HOMING_CMD_O), .DISPLAY_FLASH_O(DISPLAY_FLASH_O),
    .MOTOR_RECOG_O(MOTOR_RECOG_O));
